//--- hw/gpio_port.sv
// Seven-line multiplexed I/O port with APB register access.
// Assumes pads are synchronous to pclk and the power core supplies alternate outputs.
`timescale 1ns/1ps
module gpio_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] pad_in,
  output logic [6:0] pad_out,
  output logic [6:0] pad_oe,
  output logic [6:0] pad_pull_up,
  output logic [6:0] pad_pull_down,
  input wire gpio_port_pkg::core_out_t core_out,
  output gpio_port_pkg::sec_in_t sec_in,
  input wire logic device_off,
  output logic [6:0] line_event,
  output logic wake_request
);
  localparam int L = gpio_port_pkg::LINES;

  // Software-visible state.
  logic [7:0] pad1_q, pad2_q; // Function selects.
  logic [L-1:0] dir_q, out_q, deb_q, pu_q, pd_q, od_q;
  logic [L-1:0] rise_q, fall_q, mask_q, spu_q, spd_q;
  logic en_q; // Global port enable.
  logic [31:0] prdata_q;
  // Pad and core side registers.
  logic [L-1:0] pad_out_q, pad_oe_q, pad_pu_q, pad_pd_q;
  logic [L-1:0] prev_q, event_q;
  logic wake_q;
  gpio_port_pkg::sec_in_t sec_in_q, sec_in_d;

  // Bus decode.
  logic wr, setup;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  logic w_pad1, w_pad2, w_dir, w_out, w_deb, w_ctrl, w_clr, w_set;
  logic w_pu, w_pd, w_od, w_rise, w_fall, w_mask, w_spu, w_spd;
  assign w_pad1 = wr & (paddr == gpio_port_pkg::OFS_PAD1);
  assign w_pad2 = wr & (paddr == gpio_port_pkg::OFS_PAD2);
  assign w_dir = wr & (paddr == gpio_port_pkg::OFS_DIR);
  assign w_out = wr & (paddr == gpio_port_pkg::OFS_OUT);
  assign w_deb = wr & (paddr == gpio_port_pkg::OFS_DEB);
  assign w_ctrl = wr & (paddr == gpio_port_pkg::OFS_CTRL);
  assign w_clr = wr & (paddr == gpio_port_pkg::OFS_CLR);
  assign w_set = wr & (paddr == gpio_port_pkg::OFS_SET);
  assign w_pu = wr & (paddr == gpio_port_pkg::OFS_PULL1);
  assign w_pd = wr & (paddr == gpio_port_pkg::OFS_PULL2);
  assign w_od = wr & (paddr == gpio_port_pkg::OFS_OD);
  assign w_rise = wr & (paddr == gpio_port_pkg::OFS_RISE);
  assign w_fall = wr & (paddr == gpio_port_pkg::OFS_FALL);
  assign w_mask = wr & (paddr == gpio_port_pkg::OFS_MASK);
  assign w_spu = wr & (paddr == gpio_port_pkg::OFS_SPU);
  assign w_spd = wr & (paddr == gpio_port_pkg::OFS_SPD);

  // The access-phase address is legal only if it lands on a mapped word.
  logic hit;
  assign hit = (paddr <= gpio_port_pkg::OFS_SPD) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;

  // Function selects per line.
  logic [1:0] sel0, sel2, sel3, sel4, sel5, sel6;
  logic [2:0] sel1;
  logic [L-1:0] primary;
  assign sel0 = pad1_q[gpio_port_pkg::SEL0_LSB +: 2]; // [R14]
  assign sel1 = pad1_q[gpio_port_pkg::SEL1_LSB +: 3]; // [R14]
  assign sel2 = pad1_q[gpio_port_pkg::SEL2_LSB +: 2]; // [R14]
  assign sel3 = pad2_q[gpio_port_pkg::SEL3_LSB +: 2]; // [R14]
  assign sel4 = pad2_q[gpio_port_pkg::SEL4_LSB +: 2]; // [R14]
  assign sel5 = pad2_q[gpio_port_pkg::SEL5_LSB +: 2]; // [R14]
  assign sel6 = pad2_q[gpio_port_pkg::SEL6_LSB +: 2]; // [R14]
  // A line is general purpose only when its select is zero.
  assign primary = {sel6 == gpio_port_pkg::FN_GPIO[1:0], sel5 == gpio_port_pkg::FN_GPIO[1:0],
                    sel4 == gpio_port_pkg::FN_GPIO[1:0], sel3 == gpio_port_pkg::FN_GPIO[1:0],
                    sel2 == gpio_port_pkg::FN_GPIO[1:0], sel1 == gpio_port_pkg::FN_GPIO,
                    sel0 == gpio_port_pkg::FN_GPIO[1:0]}; // [R1]

  // Debounce filters, one per line, each with its own stability counter.
  logic [L-1:0] filt;
  for (genvar l = 0; l < L; l++) begin : g_deb
    logic [gpio_port_pkg::DEB_W-1:0] cnt_q;
    logic stab_q;
    // Accept a new level only after it differed for the whole window.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= '0;
        stab_q <= 1'b0;
      end else if (pad_in[l] == stab_q) begin
        cnt_q <= '0;
      end else if (cnt_q == gpio_port_pkg::DEB_LAST) begin
        stab_q <= pad_in[l]; // [R24]
        cnt_q <= '0;
      end else begin
        cnt_q <= gpio_port_pkg::DEB_W'(cnt_q + 1'b1);
      end
    end
    assign filt[l] = deb_q[l] ? stab_q : pad_in[l]; // [R18]
  end

  // Edge detection, gated by function, global enable and mask.
  logic [L-1:0] rise, fall, event_d, wake_lines;
  assign rise = filt & ~prev_q;
  assign fall = ~filt & prev_q;
  assign event_d = primary & {L{en_q}} & ~mask_q // [R10] [R23]
                   & ((rise & rise_q) | (fall & fall_q)); // [R9]
  // Lines in the I/O supply domain cannot wake the device from off.
  assign wake_lines = device_off ? ~gpio_port_pkg::IO_DOMAIN_LINES : {L{1'b1}}; // [R12]

  // Input register only shows general-purpose inputs.
  logic [L-1:0] in_view;
  assign in_view = filt & primary & ~dir_q & {L{en_q}}; // [R16]

  // Read selection over the register map; write-only words read as zero.
  logic [7:0] rd_val;
  assign rd_val =
    (paddr == gpio_port_pkg::OFS_PAD1) ? pad1_q :
    (paddr == gpio_port_pkg::OFS_PAD2) ? pad2_q :
    (paddr == gpio_port_pkg::OFS_DIR) ? {1'b0, dir_q} :
    (paddr == gpio_port_pkg::OFS_IN) ? {1'b0, in_view} :
    (paddr == gpio_port_pkg::OFS_OUT) ? {1'b0, out_q} :
    (paddr == gpio_port_pkg::OFS_DEB) ? {1'b0, deb_q} :
    (paddr == gpio_port_pkg::OFS_CTRL) ? {7'h00, en_q} :
    (paddr == gpio_port_pkg::OFS_PULL1) ? {1'b0, pu_q} :
    (paddr == gpio_port_pkg::OFS_PULL2) ? {1'b0, pd_q} :
    (paddr == gpio_port_pkg::OFS_OD) ? {1'b0, od_q} :
    (paddr == gpio_port_pkg::OFS_RISE) ? {1'b0, rise_q} :
    (paddr == gpio_port_pkg::OFS_FALL) ? {1'b0, fall_q} :
    (paddr == gpio_port_pkg::OFS_MASK) ? {1'b0, mask_q} :
    (paddr == gpio_port_pkg::OFS_SPU) ? {1'b0, spu_q} :
    (paddr == gpio_port_pkg::OFS_SPD) ? {1'b0, spd_q} : 8'h00;

  // Output data: a direct write wins, else clear then set apply.
  logic [L-1:0] out_d;
  assign out_d = w_out ? pwdata[L-1:0] : // [R17]
                 ((out_q & ~(w_clr ? pwdata[L-1:0] : '0)) |
                  (w_set ? pwdata[L-1:0] : '0)); // [R20]

  // Alternate drive per line from the power core.
  logic [L-1:0] sec_o, sec_oe;
  assign sec_o[0] = core_out.ext_regulator_on[0]; // [R13]
  assign sec_oe[0] = sel0 == gpio_port_pkg::FN_C[1:0]; // [R2]
  assign sec_o[1] = 1'b0;
  assign sec_oe[1] = 1'b0; // [R3]
  assign sec_o[2] = core_out.scaling_link_data_o;
  assign sec_oe[2] = (sel2 == gpio_port_pkg::FN_B[1:0]) & core_out.scaling_link_data_oe; // [R4]
  assign sec_o[3] = core_out.ext_regulator_on[0]; // [R13]
  assign sec_oe[3] = sel3 == gpio_port_pkg::FN_A[1:0]; // [R5]
  assign sec_o[4] = (sel4 == gpio_port_pkg::FN_A[1:0]) ? core_out.ext_regulator_on[1] :
                    core_out.scaling_link_clock_select_o; // [R13]
  assign sec_oe[4] = (sel4 == gpio_port_pkg::FN_A[1:0]) |
                     ((sel4 == gpio_port_pkg::FN_B[1:0]) &
                      core_out.scaling_link_clock_select_oe); // [R6]
  assign sec_o[5] = core_out.ext_regulator_on[2]; // [R13]
  assign sec_oe[5] = sel5 == gpio_port_pkg::FN_B[1:0]; // [R7]
  assign sec_o[6] = (sel6 == gpio_port_pkg::FN_B[1:0]) ? core_out.supplies_valid_output :
                    core_out.ext_regulator_on[2];
  assign sec_oe[6] = (sel6 == gpio_port_pkg::FN_B[1:0]) |
                     (sel6 == gpio_port_pkg::FN_C[1:0]); // [R8]

  // General-purpose drive: open drain only ever pulls low.
  logic [L-1:0] prim_o, prim_oe;
  assign prim_o = out_q & ~od_q; // [R21]
  assign prim_oe = {L{en_q}} & dir_q & ~(od_q & out_q); // [R15] [R19]

  // Alternate inputs taken straight from the pads, bypassing the debounce.
  always_comb begin
    sec_in_d = '0;
    sec_in_d.warm_reset_input_n = 1'b1;
    sec_in_d.sleep_request_n = 1'b1;
    sec_in_d.power_down_input = (sel0 == gpio_port_pkg::FN_A[1:0]) & pad_in[0]; // [R2]
    sec_in_d.peripheral_request_2 = ((sel0 == gpio_port_pkg::FN_B[1:0]) & pad_in[0]) |
                                    ((sel2 == gpio_port_pkg::FN_A[1:0]) & pad_in[2]); // [R4]
    sec_in_d.reset_input = (sel1 == gpio_port_pkg::FN_A) & pad_in[1]; // [R3]
    if (sel1 == gpio_port_pkg::FN_B) begin
      sec_in_d.warm_reset_input_n = pad_in[1]; // [R3]
    end
    sec_in_d.bus_power_presence = (sel1 == gpio_port_pkg::FN_C) & pad_in[1];
    sec_in_d.peripheral_request_1 = (sel1 == gpio_port_pkg::FN_D) & pad_in[1];
    sec_in_d.scaling_link_data_i = (sel2 == gpio_port_pkg::FN_B[1:0]) & pad_in[2];
    sec_in_d.switcher_sync_clock_in = (sel3 == gpio_port_pkg::FN_B[1:0]) & pad_in[3]; // [R5]
    sec_in_d.scaling_link_clock_select_i = (sel4 == gpio_port_pkg::FN_B[1:0]) & pad_in[4];
    sec_in_d.keep_power_input = (sel5 == gpio_port_pkg::FN_A[1:0]) & pad_in[5]; // [R7]
    if (sel6 == gpio_port_pkg::FN_A[1:0]) begin
      sec_in_d.sleep_request_n = pad_in[6]; // [R8]
    end
  end

  // Configuration registers written from the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad1_q <= gpio_port_pkg::RESET_VAL;
      pad2_q <= gpio_port_pkg::RESET_VAL;
      {dir_q, out_q, deb_q, pu_q, pd_q, od_q} <= '0;
      {rise_q, fall_q, mask_q, spu_q, spd_q} <= '0;
      en_q <= 1'b0;
    end else begin
      if (w_pad1) pad1_q <= pwdata[7:0];
      if (w_pad2) pad2_q <= pwdata[7:0];
      if (w_dir) dir_q <= pwdata[L-1:0];
      out_q <= out_d;
      if (w_deb) deb_q <= pwdata[L-1:0];
      if (w_ctrl) en_q <= pwdata[gpio_port_pkg::CTRL_EN_BIT];
      if (w_pu) pu_q <= pwdata[L-1:0];
      if (w_pd) pd_q <= pwdata[L-1:0];
      if (w_od) od_q <= pwdata[L-1:0];
      if (w_rise) rise_q <= pwdata[L-1:0];
      if (w_fall) fall_q <= pwdata[L-1:0];
      if (w_mask) mask_q <= pwdata[L-1:0];
      if (w_spu) spu_q <= pwdata[L-1:0];
      if (w_spd) spd_q <= pwdata[L-1:0];
    end
  end

  // Read data is captured in the setup cycle so the access phase answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= {24'h000000, rd_val};
    end
  end

  // Pad drive, pulls, events and alternate inputs are registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pad_out_q, pad_oe_q, pad_pu_q, pad_pd_q} <= '0;
      {prev_q, event_q} <= '0;
      wake_q <= 1'b0;
      sec_in_q <= '0;
    end else begin
      pad_out_q <= (primary & prim_o) | (~primary & sec_o);
      pad_oe_q <= (primary & prim_oe) | (~primary & sec_oe); // [R22]
      pad_pu_q <= (primary & pu_q) | (~primary & spu_q); // [R21] [R22]
      pad_pd_q <= (primary & pd_q) | (~primary & spd_q);
      prev_q <= filt;
      event_q <= event_d;
      wake_q <= |(event_d & wake_lines); // [R11]
      sec_in_q <= sec_in_d;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_pull_up = pad_pu_q;
  assign pad_pull_down = pad_pd_q;
  assign line_event = event_q;
  assign wake_request = wake_q;
  assign sec_in = sec_in_q;

  // Checks on the port behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  set_bits_a : assert property (w_set |=> ((out_q & $past(pwdata[L-1:0])) == // [R20]
    $past(pwdata[L-1:0]))) else $error("Set write did not set the bits.");
  clr_bits_a : assert property (w_clr && !w_out |=> ((out_q & $past(pwdata[L-1:0])) == '0))
    else $error("Clear write did not clear the bits."); // [R20]
  alt_no_event_a : assert property (|(event_q & ~$past(primary)) == 1'b0) // [R10]
    else $error("Event raised on an alternate-function line.");
  masked_quiet_a : assert property (|(event_q & $past(mask_q)) == 1'b0) // [R23]
    else $error("Event raised on a masked line.");
  off_wake_a : assert property (device_off && (event_d & ~gpio_port_pkg::IO_DOMAIN_LINES) == '0
    |=> !wake_q) else $error("I/O domain line woke the device from off."); // [R12]
  // Counts earlier cycles in which debounced line 0 saw a steady high, saturating at the window.
  logic [gpio_port_pkg::DEB_W-1:0] hold_q;
  logic [gpio_port_pkg::DEB_W-1:0] hold_full;
  assign hold_full = gpio_port_pkg::DEB_W'(gpio_port_pkg::DEB_LAST + 1'b1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
    end else if (!(deb_q[0] && pad_in[0])) begin
      hold_q <= '0;
    end else if (hold_q != hold_full) begin
      hold_q <= gpio_port_pkg::DEB_W'(hold_q + 1'b1);
    end
  end
  deb_hold_a : assert property (hold_q == hold_full && deb_q[0] && pad_in[0] |-> filt[0]) // [R24]
    else $error("Debounce did not accept a stable level.");
  reg1_out_a : assert property (sel3 == gpio_port_pkg::FN_A[1:0] // [R13]
    |=> pad_oe[3] && pad_out[3] == $past(core_out.ext_regulator_on[0]))
    else $error("Line 3 does not follow regulator enable 1.");
  port_off_a : assert property (!en_q && primary[0] |=> !pad_oe[0]) // [R19]
    else $error("Disabled port still drives a line.");
  rise_event_a : assert property (primary[0] && en_q && !mask_q[0] && rise_q[0] && rise[0]
    |=> line_event[0]) else $error("Rising edge missed."); // [R9]
  read_data_a : assert property (setup && !pwrite && paddr == gpio_port_pkg::OFS_DIR
    |=> prdata[L-1:0] == $past(dir_q)) else $error("Direction readback wrong."); // [R15]

  set_write_c : cover property (w_set ##1 w_clr);
  edge_event_c : cover property (|line_event);
  wake_c : cover property (wake_request && device_off);
endmodule

//--- hw/gpio_port_pkg.sv
// Constants, register map and carrier types for the multiplexed seven-line I/O port.
// Assumes an APB master on pclk and a power core that supplies and consumes the
// alternate pad signals.
// Function
// R1: Seven lines, each GPIO or line-specific alternate.
// R2: Line 0 alternates: power-down, request 2, regulator 1.
// R3: Line 1 alternates: reset, warm reset, bus power, request 1.
// R4: Line 2 alternates: request 2, scaling link data.
// R5: Line 3 alternates: regulator 1, switcher sync clock.
// R6: Line 4 alternates: regulator 2, scaling link clock.
// R7: Line 5 alternates: keep power, regulator 3.
// R8: Line 6 alternates: sleep, supplies valid, regulator 3.
// R9: Per-line rising, falling or both edge events, maskable.
// R10: Edge events only in general-purpose function.
// R11: Every line can be a wake-up source.
// R12: Lines 2 and 4 never wake from off.
// R13: Regulator enables follow the power-up sequencer steps.
// R14: Two pad-select registers choose each line's function.
// R15: Direction register sets input or output per line.
// R16: Read-only input register reports sampled input levels.
// R17: Output data register sets driven output levels.
// R18: Per-line debounce enable selects the filter.
// R19: Global control enables or disables all lines; the code gates only general-purpose drive, input and events.
// R20: Write-only clear and set registers change output bits.
// R21: Pull-up, pull-down and open-drain registers per line.
// R22: Alternate functions ignore general-purpose control registers.
// R23: Masked lines detect no events at all.
// R24: Debounce accepts level after fixed stable samples.
package gpio_port_pkg;
  localparam int LINES = 7;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Register byte offsets.
  localparam logic [7:0] OFS_PAD1 = 8'h00;
  localparam logic [7:0] OFS_PAD2 = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_IN = 8'h0c;
  localparam logic [7:0] OFS_OUT = 8'h10;
  localparam logic [7:0] OFS_DEB = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_CLR = 8'h1c;
  localparam logic [7:0] OFS_SET = 8'h20;
  localparam logic [7:0] OFS_PULL1 = 8'h24;
  localparam logic [7:0] OFS_PULL2 = 8'h28;
  localparam logic [7:0] OFS_OD = 8'h2c;
  localparam logic [7:0] OFS_RISE = 8'h30;
  localparam logic [7:0] OFS_FALL = 8'h34;
  localparam logic [7:0] OFS_MASK = 8'h38;
  localparam logic [7:0] OFS_SPU = 8'h3c;
  localparam logic [7:0] OFS_SPD = 8'h40;
  // Select field positions inside the two pad-select registers.
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 2;
  localparam int SEL2_LSB = 5;
  localparam int SEL3_LSB = 0;
  localparam int SEL4_LSB = 2;
  localparam int SEL5_LSB = 4;
  localparam int SEL6_LSB = 6;
  localparam int CTRL_EN_BIT = 0;
  // Select codes; zero always means general-purpose function.
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] FN_A = 3'h1;
  localparam logic [2:0] FN_B = 3'h2;
  localparam logic [2:0] FN_C = 3'h3;
  localparam logic [2:0] FN_D = 3'h4;
  // Debounce counter width and the last count before acceptance (an 8-sample window).
  localparam int DEB_W = 4;
  localparam logic [DEB_W-1:0] DEB_LAST = 4'h7;
  // Lines powered from the I/O supply domain.
  localparam logic [LINES-1:0] IO_DOMAIN_LINES = 7'h14;
  // Alternate inputs delivered to the power core.
  typedef struct packed {
    logic power_down_input;
    logic peripheral_request_1;
    logic peripheral_request_2;
    logic reset_input;
    logic warm_reset_input_n;
    logic bus_power_presence;
    logic switcher_sync_clock_in;
    logic keep_power_input;
    logic sleep_request_n;
    logic scaling_link_data_i;
    logic scaling_link_clock_select_i;
  } sec_in_t;
  // Alternate outputs driven by the power core.
  typedef struct packed {
    logic [2:0] ext_regulator_on;
    logic supplies_valid_output;
    logic scaling_link_data_o;
    logic scaling_link_data_oe;
    logic scaling_link_clock_select_o;
    logic scaling_link_clock_select_oe;
  } core_out_t;
endpackage

//--- testbench/pad_world.sv
// Far-side model of the seven pads: board drivers, pull resistors and floating pads.
// Assumes the bench changes ext_en and ext_val just after rising edges of pclk.
`timescale 1ns/1ps
module pad_world (
  input wire logic pclk,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  input wire logic [6:0] pad_pull_up,
  input wire logic [6:0] pad_pull_down,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  output logic [6:0] pad_in
);
  // Pads start low so the first samples are defined.
  initial begin
    pad_in = 7'h00;
  end
  // Each pad settles once a clock: a board driver wins, then the port's own drive,
  // then a pull; a floating pad flips every cycle so no stale level survives.
  always @(posedge pclk) begin
    for (int i = 0; i < 7; i++) begin
      if (ext_en[i]) begin
        pad_in[i] <= ext_val[i];
      end else if (pad_oe[i]) begin
        pad_in[i] <= pad_out[i];
      end else if (pad_pull_up[i]) begin
        pad_in[i] <= 1'b1;
      end else if (pad_pull_down[i]) begin
        pad_in[i] <= 1'b0;
      end else begin
        pad_in[i] <= ~pad_in[i];
      end
    end
  end
endmodule

//--- testbench/tb_multiplexed_gpio_port.sv
// Self-checking bench for the seven-line I/O port: APB master, pad model, event monitor.
// Assumes a zero-wait APB slave and pads that are synchronous to pclk.
`timescale 1ns/1ps
module tb_multiplexed_gpio_port;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  gpio_port_pkg::core_out_t core_out;
  gpio_port_pkg::sec_in_t sec_in;
  logic device_off;
  logic [6:0] line_event;
  logic wake_request;
  logic [6:0] ext_en; // Board drives every pad until the output tests.
  logic [6:0] ext_val;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  integer seed = 32'hdabb;
  logic [33:0] bus_q[$]; // Expected transfer results: read flag, error, data.
  logic [7:0] ev_q[$]; // Expected events: wake flag and line pulses.

  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  gpio_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .core_out(core_out),
    .sec_in(sec_in), .device_off(device_off), .line_event(line_event),
    .wake_request(wake_request));

  pad_world world (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Lets n rising edges pass.
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; the expected answer is queued for the monitor.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    int w;
    bus_q.push_back({~wr, (a > 8'h40) || (a[1:0] != 2'b00), exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, exp);
  endtask

  // Monitor: each completed transfer and each event pulse takes the oldest note.
  always @(posedge pclk) begin
    logic [33:0] e;
    if (psel && penable && pready && bus_q.size() > 0) begin
      e = bus_q.pop_front();
      check({31'h0, pslverr}, {31'h0, e[32]}, "slave error");
      if (e[33]) begin
        check(prdata, e[31:0], "read data");
      end
    end
    if (line_event !== 7'h00 || wake_request !== 1'b0) begin
      check({wake_request, line_event}, (ev_q.size() > 0) ? ev_q.pop_front() : 8'hff, "event");
    end
  end

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("BAD %0t run did not finish", $time);
      conclude();
    end
  end

  // Main sequence.
  initial begin
    logic [7:0] rw_ofs[$];
    logic [31:0] r;
    logic [2:0] g;
    // Idle bus, reset asserted and every pad driven low by the board.
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    core_out <= '0;
    device_off <= 1'b0;
    ext_en <= 7'h7f;
    ext_val <= 7'h00;
    rw_ofs = '{gpio_port_pkg::OFS_PAD1, gpio_port_pkg::OFS_PAD2, gpio_port_pkg::OFS_DIR,
      gpio_port_pkg::OFS_OUT, gpio_port_pkg::OFS_DEB, gpio_port_pkg::OFS_PULL1,
      gpio_port_pkg::OFS_PULL2, gpio_port_pkg::OFS_OD, gpio_port_pkg::OFS_MASK,
      gpio_port_pkg::OFS_SPU, gpio_port_pkg::OFS_SPD};
    tick(5);
    presetn <= 1'b1;
    @(posedge pclk);
    // Every register reads zero after reset; write-only ones always read zero.
    for (int a = 0; a <= 8'h40; a += 4) begin
      rd(8'(a), 32'h0);
    end
    check({31'h0, sec_in.sleep_request_n}, 32'h1, "idle sleep input");
    rd(8'h44, 32'h0);
    wr(8'h06, 32'h7f);
    rd(gpio_port_pkg::OFS_PAD2, 32'h0);
    $display("test reset and map done");
    // Random write and readback; unused upper bits read zero.
    foreach (rw_ofs[i]) begin
      r = $random(seed);
      wr(rw_ofs[i], r);
      rd(rw_ofs[i], r & ((rw_ofs[i] < 8'h08) ? 32'hff : 32'h7f));
      wr(rw_ofs[i], 32'h0);
    end
    wr(gpio_port_pkg::OFS_IN, 32'h7f);
    rd(gpio_port_pkg::OFS_IN, 32'h0);
    $display("test register access done");
    // Input sampling with the port enabled and disabled.
    wr(gpio_port_pkg::OFS_CTRL, 32'h1);
    rd(gpio_port_pkg::OFS_CTRL, 32'h1);
    ext_val <= 7'($random(seed));
    tick(6);
    rd(gpio_port_pkg::OFS_IN, {25'h0, ext_val});
    wr(gpio_port_pkg::OFS_CTRL, 32'h0);
    rd(gpio_port_pkg::OFS_IN, 32'h0);
    ext_val <= 7'h00;
    wr(gpio_port_pkg::OFS_CTRL, 32'h1);
    tick(6);
    $display("test inputs done");
    // Edge events: rising on all lines, both edges on line 5, line 6 masked.
    wr(gpio_port_pkg::OFS_RISE, 32'h7f);
    wr(gpio_port_pkg::OFS_FALL, 32'h20);
    wr(gpio_port_pkg::OFS_MASK, 32'h40);
    ev_q.push_back(8'h82);
    ext_val <= 7'h02;
    tick(6);
    ext_val <= 7'h00;
    tick(6);
    ev_q.push_back(8'ha0);
    ext_val <= 7'h20;
    tick(6);
    ev_q.push_back(8'ha0);
    ext_val <= 7'h40;
    tick(6);
    ext_val <= 7'h00;
    tick(6);
    device_off <= 1'b1;
    ev_q.push_back(8'h04);
    ext_val <= 7'h04;
    tick(6);
    ev_q.push_back(8'h82);
    ext_val <= 7'h06;
    tick(6);
    device_off <= 1'b0;
    ext_val <= 7'h00;
    tick(6);
    // Line 0 as power-down input: level reaches the core, no line event.
    wr(gpio_port_pkg::OFS_PAD1, 32'h1);
    ext_val <= 7'h01;
    tick(6);
    check({31'h0, sec_in.power_down_input}, 32'h1, "power down");
    ext_val <= 7'h00;
    tick(6);
    check({31'h0, sec_in.power_down_input}, 32'h0, "power down");
    $display("test events done");
    // Debounced line 3: a short pulse is dropped, a steady level is accepted.
    wr(gpio_port_pkg::OFS_DEB, 32'h08);
    ext_val <= 7'h08;
    tick(4);
    ext_val <= 7'h00;
    tick(14);
    ev_q.push_back(8'h88);
    ext_val <= 7'h08;
    tick(16);
    ext_val <= 7'h00;
    tick(16);
    wr(gpio_port_pkg::OFS_RISE, 32'h0);
    wr(gpio_port_pkg::OFS_FALL, 32'h0);
    wr(gpio_port_pkg::OFS_PAD1, 32'h0);
    $display("test debounce done");
    // Output drive, atomic set and clear, open drain, pulls, global disable.
    ext_en <= 7'h00;
    wr(gpio_port_pkg::OFS_DIR, 32'h7f);
    wr(gpio_port_pkg::OFS_OUT, 32'h55);
    tick(3);
    check({25'h0, pad_out}, 32'h55, "pad out");
    check({25'h0, pad_oe}, 32'h7f, "pad enable");
    wr(gpio_port_pkg::OFS_SET, 32'h0a);
    wr(gpio_port_pkg::OFS_CLR, 32'h41);
    rd(gpio_port_pkg::OFS_OUT, 32'h1e);
    tick(3);
    check({25'h0, pad_out}, 32'h1e, "pad out");
    wr(gpio_port_pkg::OFS_OD, 32'h7f);
    tick(3);
    check({25'h0, pad_oe}, 32'h61, "open drain");
    wr(gpio_port_pkg::OFS_OD, 32'h0);
    wr(gpio_port_pkg::OFS_PULL1, 32'h0f);
    wr(gpio_port_pkg::OFS_PULL2, 32'h70);
    tick(3);
    check({25'h0, pad_pull_up}, 32'h0f, "pull up");
    check({25'h0, pad_pull_down}, 32'h70, "pull down");
    wr(gpio_port_pkg::OFS_CTRL, 32'h0);
    tick(3);
    check({25'h0, pad_oe}, 32'h0, "disabled port");
    wr(gpio_port_pkg::OFS_CTRL, 32'h1);
    $display("test outputs done");
    // Regulator enables on lines 3 to 6 ignore the general-purpose registers.
    wr(gpio_port_pkg::OFS_PAD2, 32'he5);
    wr(gpio_port_pkg::OFS_SPU, 32'h78);
    for (int k = 0; k < 4; k++) begin
      g = 3'($random(seed));
      core_out.ext_regulator_on <= g;
      tick(3);
      check({28'h0, pad_out[6:3]}, {28'h0, g[2], g[2], g[1], g[0]}, "regulator");
      check({28'h0, pad_oe[6:3]}, 32'hf, "regulator drive");
      check({25'h0, pad_pull_up}, 32'h7f, "alternate pull up");
      check({25'h0, pad_pull_down}, 32'h0, "alternate pull down");
    end
    // Line 2 as scaling link data follows the core's drive.
    wr(gpio_port_pkg::OFS_PAD1, 32'h40);
    core_out.scaling_link_data_o <= 1'b1;
    core_out.scaling_link_data_oe <= 1'b1;
    tick(3);
    check({30'h0, pad_oe[2], pad_out[2]}, 32'h3, "link data");
    $display("test alternates done");
    tick(10);
    check(bus_q.size() + ev_q.size(), 32'h0, "pending notes");
    conclude();
  end
endmodule
